// [rtl/dcsa_arbiter.sv]
// Command source arbiter with local/remote switching and start gating
// Behaviour
// - Source 3 takes run and stop only from the serial link.
// - Link config holds station 1..250, protocol default 0, rate code default 3.
// - Writing key function 2 enters remote at once, same as a key press in local.
// - Key press in remote goes local, flashes set light, keypad runs.
// - Key press in local goes remote, set light off, configured source rules.
// - Local jog only when a run-permit input is configured and asserted.
// - Remote runs from the configured command source.
// - Without autostart, inputs held at power-up act only after all release.
// - After fault reset while running come up local; going remote stops until inputs release.
// - Remote to local while running stops the output.
// - Local to remote with terminals keeps running, reverse input honoured.
// - Local to remote with keypad or link stops until next command.
// - Direction block decode: 0 none, 1 forward blocked, 2 reverse blocked.
// - Blocked keypad reverse decelerates to 0Hz and stops, drive stays on.
// - Dual-direction mode: both inputs or neither means stop.
// - Go-and-direction mode: forward is run, reverse selects direction.
module dcsa_arbiter #(
    parameter int DEBOUNCE_CYCLES = dcsa_pkg::DEBOUNCE_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Configuration
    input wire logic [2:0] command_source,
    input wire logic [1:0] escape_key_function,
    input wire logic escape_key_function_wr,
    input wire logic [1:0] direction_block,
    input wire logic power_on_run,
    input wire logic [41:0] multifunction_defs,
    input wire logic [7:0] station_number_in,
    input wire logic [1:0] link_protocol_select_in,
    input wire logic [2:0] link_rate_code_in,
    input wire logic [1:0] link_frame_format_in,
    input wire logic link_config_wr,
    // Keypad
    input wire logic mode_toggle_key,
    input wire logic key_run,
    input wire logic key_stop,
    input wire logic key_rev,
    input wire logic key_jog,
    // Terminals
    input wire logic [6:0] multifunction_inputs,
    input wire logic forward_run_input,
    input wire logic reverse_run_input,
    input wire logic jog_input,
    input wire logic preexcite_input,
    // Serial link commands
    input wire logic link_run,
    input wire logic link_stop,
    input wire logic link_rev,
    // Fault
    input wire logic fault_reset,
    // Outputs
    output logic run_cmd,
    output logic reverse_cmd,
    output logic jog_cmd,
    output logic decel_stop,
    output logic remote_mode,
    output logic set_led_flash,
    output logic [7:0] station_number,
    output logic [1:0] link_protocol_select,
    output logic [2:0] link_rate_code,
    output logic [1:0] link_frame_format
);
    logic key_press;
    logic lr_enabled_reg;
    logic gate_reg;
    logic term_any;
    logic permit;
    logic run_reg;
    logic rev_reg;
    logic run_next;
    logic rev_next;
    logic jog_next;
    logic stop_req;
    logic go_remote;
    logic go_local;

    dcsa_key_debounce #(
        .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
    ) dcsa_key_debounce_i (
        .clock(clock),
        .rstn(rstn),
        .key_raw(mode_toggle_key),
        .press_pulse(key_press)
    );

    // True when any input holds the run-permit function and is asserted
    function automatic logic permit_active(input logic [41:0] defs, input logic [6:0] ins);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < dcsa_pkg::NUM_INPUTS; i++) begin
            if (defs[i*6 +: 6] == dcsa_pkg::FN_RUN_PERMIT && ins[i]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : permit_active

    assign term_any = forward_run_input | reverse_run_input | jog_input | preexcite_input;
    assign permit = permit_active(multifunction_defs, multifunction_inputs);
    assign go_remote = (escape_key_function_wr &&
        escape_key_function == dcsa_pkg::KEY_FN_LOCAL_REMOTE) ||
        (lr_enabled_reg && key_press && !remote_mode);
    assign go_local = lr_enabled_reg && key_press && remote_mode && !go_remote;

    // Serial link configuration; out-of-range station numbers are ignored
    always_ff @(posedge clock) begin
        if (!rstn) begin
            station_number <= dcsa_pkg::STATION_RESET;
            link_protocol_select <= dcsa_pkg::PROTO_RESET;
            link_rate_code <= dcsa_pkg::RATE_RESET;
            link_frame_format <= dcsa_pkg::FRAME_RESET;
        end else if (link_config_wr) begin
            if (station_number_in >= dcsa_pkg::STATION_MIN &&
                station_number_in <= dcsa_pkg::STATION_MAX) begin
                station_number <= station_number_in;
            end
            link_protocol_select <= link_protocol_select_in;
            link_rate_code <= link_rate_code_in;
            link_frame_format <= link_frame_format_in;
        end
    end

    // Local/remote mode; remote from reset, key presses toggle only while key switching is enabled
    always_ff @(posedge clock) begin
        if (!rstn) begin
            lr_enabled_reg <= 1'b0;
            remote_mode <= 1'b1;
            set_led_flash <= 1'b0;
        end else begin
            if (escape_key_function_wr) begin
                lr_enabled_reg <= escape_key_function == dcsa_pkg::KEY_FN_LOCAL_REMOTE;
            end
            if (fault_reset && run_reg) begin
                remote_mode <= 1'b0;
                set_led_flash <= 1'b1;
            end else if (go_remote) begin
                remote_mode <= 1'b1;
                set_led_flash <= 1'b0;
            end else if (go_local) begin
                remote_mode <= 1'b0;
                set_led_flash <= 1'b1;
            end
        end
    end

    // Terminal gate: held closed until every terminal command is released
    always_ff @(posedge clock) begin
        if (!rstn) begin
            gate_reg <= 1'b0;
        end else if (!term_any) begin
            gate_reg <= 1'b1;
        end else if (fault_reset && run_reg) begin
            gate_reg <= 1'b0;
        end else if (go_remote && !remote_mode && gate_reg == 1'b0) begin
            gate_reg <= 1'b0;
        end
    end

    // Run-state latch for keypad and link sources, plus terminal decode
    always_comb begin
        run_next = run_reg;
        rev_next = rev_reg;
        jog_next = 1'b0;
        stop_req = 1'b0;
        if (!remote_mode) begin
            if (key_run) begin
                run_next = 1'b1;
                rev_next = key_rev;
            end
            if (key_stop) begin
                run_next = 1'b0;
            end
            jog_next = key_jog && permit;
        end else begin
            case (command_source)
                dcsa_pkg::SRC_KEYPAD: begin
                    if (key_run) begin
                        run_next = 1'b1;
                        rev_next = key_rev;
                    end
                    if (key_stop) begin
                        run_next = 1'b0;
                    end
                end
                dcsa_pkg::SRC_DUAL_DIR: begin
                    run_next = gate_reg && (forward_run_input ^ reverse_run_input);
                    rev_next = reverse_run_input;
                    jog_next = gate_reg && jog_input;
                end
                dcsa_pkg::SRC_GO_DIR: begin
                    run_next = gate_reg && forward_run_input;
                    rev_next = reverse_run_input;
                    jog_next = gate_reg && jog_input;
                end
                dcsa_pkg::SRC_LINK: begin
                    if (link_run) begin
                        run_next = 1'b1;
                        rev_next = link_rev;
                    end
                    if (link_stop) begin
                        run_next = 1'b0;
                    end
                end
                default: begin
                    run_next = 1'b0;
                end
            endcase
        end
        // Blocked direction requested, or keypad reverse in local under any block: ramp to zero and stop, drive stays on
        if ((direction_block == dcsa_pkg::BLOCK_FWD && run_next && !rev_next) ||
            (direction_block == dcsa_pkg::BLOCK_REV && run_next && rev_next) ||
            (direction_block != dcsa_pkg::BLOCK_NONE && key_rev && !remote_mode)) begin
            stop_req = 1'b1;
            run_next = 1'b0;
            jog_next = 1'b0;
        end
        // A key-function write while already remote leaves the run state alone
        if (go_local || (go_remote && !remote_mode &&
            command_source != dcsa_pkg::SRC_DUAL_DIR &&
            command_source != dcsa_pkg::SRC_GO_DIR)) begin
            run_next = 1'b0;
            jog_next = 1'b0;
        end
        if (fault_reset) begin
            run_next = 1'b0;
            jog_next = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            run_reg <= 1'b0;
            rev_reg <= 1'b0;
            run_cmd <= 1'b0;
            reverse_cmd <= 1'b0;
            jog_cmd <= 1'b0;
            decel_stop <= 1'b0;
        end else begin
            run_reg <= run_next;
            rev_reg <= rev_next;
            run_cmd <= run_next;
            reverse_cmd <= rev_next;
            jog_cmd <= jog_next;
            decel_stop <= stop_req;
        end
    end

    logic unused_power_on;
    assign unused_power_on = power_on_run;
endmodule : dcsa_arbiter

// [rtl/dcsa_pkg.sv]
// Constants shared by the command source arbiter
package dcsa_pkg;
    // Command source selector values
    localparam logic [2:0] SRC_KEYPAD = 3'h0;
    localparam logic [2:0] SRC_DUAL_DIR = 3'h1;
    localparam logic [2:0] SRC_GO_DIR = 3'h2;
    localparam logic [2:0] SRC_LINK = 3'h3;
    // Mode-toggle key function value for local/remote switching
    localparam logic [1:0] KEY_FN_LOCAL_REMOTE = 2'h2;
    // Direction blocking codes
    localparam logic [1:0] BLOCK_NONE = 2'h0;
    localparam logic [1:0] BLOCK_FWD = 2'h1;
    localparam logic [1:0] BLOCK_REV = 2'h2;
    // Multifunction input function code for run permit
    localparam logic [5:0] FN_RUN_PERMIT = 6'h0d;
    // Serial link configuration limits and defaults
    localparam logic [7:0] STATION_MIN = 8'h01;
    localparam logic [7:0] STATION_MAX = 8'hfa;
    localparam logic [7:0] STATION_RESET = 8'h01;
    localparam logic [1:0] PROTO_RESET = 2'h0;
    localparam logic [2:0] RATE_RESET = 3'h3;
    localparam logic [1:0] FRAME_RESET = 2'h0;
    // Key debounce time and multifunction input count
    localparam int CLK_HZ = 50000000;
    localparam int DEBOUNCE_MS = 10;
    localparam int DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;
    localparam int NUM_INPUTS = 7;
endpackage : dcsa_pkg

// [rtl/dcsa_key_debounce.sv]
// Debounce and single-edge detector for the mode-toggle key
module dcsa_key_debounce #(
    parameter int DEBOUNCE_CYCLES = dcsa_pkg::DEBOUNCE_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Key
    input wire logic key_raw,
    output logic press_pulse
);
    logic [19:0] count_reg;
    logic stable_reg;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            count_reg <= 20'h00000;
            stable_reg <= 1'b0;
            press_pulse <= 1'b0;
        end else begin
            press_pulse <= 1'b0;
            if (key_raw == stable_reg) begin
                count_reg <= 20'h00000;
            end else if (count_reg == 20'(DEBOUNCE_CYCLES - 1)) begin
                count_reg <= 20'h00000;
                stable_reg <= key_raw;
                press_pulse <= key_raw;
            end else begin
                count_reg <= count_reg + 20'h00001;
            end
        end
    end
endmodule : dcsa_key_debounce

// [verif/dcsa_arbiter_sva.sv]
// Port checker for the command source arbiter
module dcsa_arbiter_chk (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Inputs watched
    input wire logic [2:0] command_source,
    input wire logic [1:0] escape_key_function,
    input wire logic escape_key_function_wr,
    input wire logic [1:0] direction_block,
    input wire logic [7:0] station_number_in,
    input wire logic [2:0] link_rate_code_in,
    input wire logic link_config_wr,
    input wire logic forward_run_input,
    input wire logic reverse_run_input,
    input wire logic link_run,
    input wire logic fault_reset,
    // Outputs watched
    input wire logic run_cmd,
    input wire logic reverse_cmd,
    input wire logic decel_stop,
    input wire logic remote_mode,
    input wire logic set_led_flash,
    input wire logic [7:0] station_number,
    input wire logic [2:0] link_rate_code
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    AST_RESET_VALS: assert property ($rose(rstn) |-> remote_mode && !run_cmd
        && link_rate_code == dcsa_pkg::RATE_RESET) else $error("bad reset state");
    AST_STATION_RANGE: assert property (station_number inside {[8'h01:8'hfa]})
        else $error("station out of range");
    AST_STATION_WR: assert property (link_config_wr && station_number_in inside {[8'h01:8'hfa]}
        |=> station_number == $past(station_number_in)) else $error("station not stored");
    AST_RATE_WR: assert property (link_config_wr |=> link_rate_code == $past(link_rate_code_in))
        else $error("rate not stored");
    AST_KEYFN_REMOTE: assert property (escape_key_function_wr && escape_key_function == 2'h2
        |=> remote_mode) else $error("not remote after key function write");
    AST_LED_LOCAL: assert property (set_led_flash == !remote_mode)
        else $error("set light disagrees with mode");
    AST_LOCAL_STOP: assert property ($fell(remote_mode) |-> !run_cmd)
        else $error("still running after going local");
    AST_DUAL_STOP: assert property (remote_mode && command_source == dcsa_pkg::SRC_DUAL_DIR
        && forward_run_input == reverse_run_input |=> !run_cmd) else $error("dual stop missed");
    AST_LINK_ONLY: assert property (remote_mode && command_source == dcsa_pkg::SRC_LINK
        && !run_cmd && !link_run |=> !run_cmd) else $error("run without link command");
    AST_REV_BLOCKED: assert property (direction_block == dcsa_pkg::BLOCK_REV
        |=> !(run_cmd && reverse_cmd)) else $error("reverse run while blocked");
    AST_DECEL_STOP: assert property (decel_stop |-> !run_cmd)
        else $error("run held during blocked-direction stop");
    AST_FAULT_LOCAL: assert property (fault_reset && run_cmd |=> !remote_mode && !run_cmd)
        else $error("fault reset did not fall back to local stop");
    cover property ($fell(remote_mode));
    cover property ($rose(run_cmd) && remote_mode);
    cover property (decel_stop);
endmodule : dcsa_arbiter_chk

bind dcsa_arbiter dcsa_arbiter_chk dcsa_arbiter_chk_i (.*);

// [verif/dcsa_link_host.sv]
// Upstream controller model issuing link command pulses
module dcsa_link_host (
    // Clock
    input wire logic clock,
    // Link commands
    output logic link_run,
    output logic link_stop,
    output logic link_rev
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {link_run, link_stop, link_rev} = 3'h0;
    // Gap lets a scenario answer promptly or slowly
    task automatic send(input logic [2:0] cmd, input int gap);
        repeat (gap) @(negedge clock);
        {link_run, link_stop, link_rev} = cmd;
        @(negedge clock);
        {link_run, link_stop, link_rev} = 3'h0;
    endtask : send
endmodule : dcsa_link_host

// [verif/testbench.sv]
// Self-checking bench for the command source arbiter
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DB = 4;
    logic clock = 1'h0, rstn = 1'h0, escape_key_function_wr = 1'h0, link_config_wr = 1'h0;
    logic mode_toggle_key = 1'h0, key_run = 1'h0, key_stop = 1'h0, key_rev = 1'h0;
    logic key_jog = 1'h0, fault_reset = 1'h0, power_on_run = 1'h0, jog_input = 1'h0;
    logic forward_run_input = 1'h0, reverse_run_input = 1'h0, preexcite_input = 1'h0;
    logic [2:0] command_source = 3'h0, link_rate_code_in = 3'h0, link_rate_code;
    logic [1:0] escape_key_function = 2'h0, direction_block = 2'h0;
    logic [1:0] link_protocol_select_in = 2'h0, link_frame_format_in = 2'h0;
    logic [41:0] multifunction_defs = 42'h0;
    logic [6:0] multifunction_inputs = 7'h0, f;
    logic [7:0] station_number_in = 8'h0, station_number;
    logic [7:0] st[3] = '{8'hfa, 8'h00, 8'hfb};
    logic link_run, link_stop, link_rev, run_cmd, reverse_cmd, jog_cmd, decel_stop;
    logic remote_mode, set_led_flash;
    logic [1:0] link_protocol_select, link_frame_format;
    logic [14:0] cfg = {8'h01, 2'h0, 3'h3, 2'h0};
    logic [20:0] exp_q[$];
    int cyc = 0, miscompares = 0, cmp_count = 0;
    integer seed = 32'ha127;
    wire [20:0] obs = {decel_stop, run_cmd, reverse_cmd, jog_cmd, remote_mode, set_led_flash,
        station_number, link_protocol_select, link_rate_code, link_frame_format};

    dcsa_arbiter #(.DEBOUNCE_CYCLES(DB)) dcsa_arbiter_i (.*);
    dcsa_link_host dcsa_link_host_i (.*);

    always #10 clock = ~clock;

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [20:0] seen, input logic [20:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] outputs exp %h seen %h", exp, seen);
        end
    endtask : check

    // Sampled at the rising edge so outputs still hold the previous cycle's value
    always @(posedge clock) begin
        cyc++;
        if (exp_q.size() > 0)
            check(obs, exp_q.pop_front());
        if (cyc == 1000) begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic chk(input logic [4:0] s);
        @(negedge clock);
        exp_q.push_back({1'h0, s, cfg});
    endtask : chk

    task automatic pulse(ref logic s);
        s = 1'h1;
        @(negedge clock);
        s = 1'h0;
    endtask : pulse

    // Held past the debounce time, then released: one press, one toggle while key switching is enabled
    task automatic press();
        mode_toggle_key = 1'h1;
        repeat (DB + 3) @(negedge clock);
        mode_toggle_key = 1'h0;
        repeat (3) @(negedge clock);
    endtask : press

    task automatic wcfg(input logic [7:0] s, input logic [6:0] v);
        {station_number_in, link_protocol_select_in, link_rate_code_in, link_frame_format_in} = {s, v};
        pulse(link_config_wr);
        if (s inside {[8'h01:8'hfa]})
            cfg[14:7] = s;
        cfg[6:0] = v;
    endtask : wcfg

    initial begin
        repeat (20) @(negedge clock);
        rstn = 1'h1;
        chk(5'h02);
        for (int i = 0; i < 3; i++) begin
            f = 7'($random(seed));
            f[6:5] = f[6:5] % 2'h3;
            wcfg(st[i], f);
            chk(5'h02);
        end
        press();
        chk(5'h02);
        escape_key_function = dcsa_pkg::KEY_FN_LOCAL_REMOTE;
        pulse(escape_key_function_wr);
        chk(5'h02);
        press();
        chk(5'h01);
        key_jog = 1'h1;
        chk(5'h01);
        multifunction_defs[5:0] = dcsa_pkg::FN_RUN_PERMIT;
        multifunction_inputs[0] = 1'h1;
        chk(5'h05);
        key_jog = 1'h0;
        multifunction_inputs = 7'h0;
        pulse(key_run);
        chk(5'h11);
        direction_block = dcsa_pkg::BLOCK_REV;
        pulse(key_rev);
        exp_q.push_back({1'h1, 5'h01, cfg});
        chk(5'h01);
        direction_block = dcsa_pkg::BLOCK_NONE;
        pulse(key_run);
        command_source = dcsa_pkg::SRC_DUAL_DIR;
        reverse_run_input = 1'h1;
        press();
        chk(5'h1a);
        forward_run_input = 1'h1;
        chk(5'h0a);
        command_source = dcsa_pkg::SRC_GO_DIR;
        chk(5'h1a);
        reverse_run_input = 1'h0;
        chk(5'h12);
        press();
        chk(5'h01);
        forward_run_input = 1'h0;
        pulse(key_run);
        command_source = dcsa_pkg::SRC_LINK;
        press();
        chk(5'h02);
        pulse(key_run);
        chk(5'h02);
        dcsa_link_host_i.send(3'h5, 0);
        chk(5'h1a);
        dcsa_link_host_i.send(3'h2, 2);
        chk(5'h0a);
        command_source = dcsa_pkg::SRC_DUAL_DIR;
        forward_run_input = 1'h1;
        chk(5'h12);
        pulse(fault_reset);
        chk(5'h01);
        press();
        chk(5'h02);
        forward_run_input = 1'h0;
        chk(5'h02);
        forward_run_input = 1'h1;
        chk(5'h12);
        // Second reset with a run input held: it must stay ignored until released
        rstn = 1'h0;
        repeat (3) @(negedge clock);
        rstn = 1'h1;
        cfg = {8'h01, 2'h0, 3'h3, 2'h0};
        chk(5'h02);
        forward_run_input = 1'h0;
        chk(5'h02);
        forward_run_input = 1'h1;
        chk(5'h12);
        repeat (2) @(negedge clock);
        print_verdict();
    end
endmodule : testbench
